// >>> rtl/pie_expander.sv
// peripheral interrupt expander: pending bits, priority, vector codes
`timescale 1ns/1ps
module pie_expander
  import pie_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic wdog_reset_in,
  input wire logic soft_nmi_in,
  input wire logic [PIE_NSRC-1:0] periph_req_in,
  input wire logic power_protect_a_in,
  input wire logic power_protect_b_in,
  input wire logic ext_irq_pin_one_in,
  input wire logic ext_irq_pin_two_in,
  input wire logic [PIE_NSRC-1:0] source_enable_in,
  input wire logic [1:0] core_mask_reg_in,
  input wire logic ack_one_in,
  input wire logic ack_two_in,
  output logic core_reset_out,
  output logic nmi_take_out,
  output logic [15:0] core_vector_out,
  output logic core_line_one_out,
  output logic core_line_two_out,
  output logic [15:0] peripheral_vector_code_out,
  output logic [15:0] pending_request_regs0_out,
  output logic [15:0] pending_request_regs2_out
);
  typedef enum logic [2:0] {
    PIE_RUN = 3'b001,
    PIE_RST = 3'b010,
    PIE_NMI = 3'b100
  } pie_state_e;

  logic [3:0] pins_s;
  logic [PIE_NSRC-1:0] raw_req;
  logic [PIE_NSRC-1:0] pend_q, pend_d;
  logic [PIE_NSRC-1:0] live;
  logic hit1, hit2;
  logic [PIE_IDX_W-1:0] idx1, idx2;
  logic [15:0] piv_q, piv_d;
  logic [15:0] vec_q, vec_d;
  logic rst_q, rst_d, nmi_q, nmi_d;
  pie_state_e st_q, st_d;
  logic [15:0] bank0, bank2;

  pie_sync #(.W(4)) u_sync (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .d_in({ext_irq_pin_two_in, ext_irq_pin_one_in, power_protect_b_in, power_protect_a_in}),
    .q_out(pins_s)
  );

  // pins on their table slots, peripherals elsewhere
  always_comb begin
    raw_req = periph_req_in;
    raw_req[0] = pins_s[0];
    raw_req[1] = pins_s[1];
    raw_req[3] = pins_s[2];
    raw_req[4] = pins_s[3];
  end

  // enabled requests that the core mask lets through
  always_comb begin
    live = pend_q & source_enable_in;
    for (int i = PIE_LINE_ONE_LO; i <= PIE_LINE_ONE_HI; i++) begin
      live[i] = live[i] & core_mask_reg_in[0];
    end
    for (int i = PIE_LINE_TWO_LO; i <= PIE_LINE_TWO_HI; i++) begin
      live[i] = live[i] & core_mask_reg_in[1];
    end
  end

  pie_pick #(.LO(PIE_LINE_ONE_LO), .HI(PIE_LINE_ONE_HI)) u_pick1 (
    .req_in(live),
    .hit_out(hit1),
    .idx_out(idx1)
  );
  pie_pick #(.LO(PIE_LINE_TWO_LO), .HI(PIE_LINE_TWO_HI)) u_pick2 (
    .req_in(live),
    .hit_out(hit2),
    .idx_out(idx2)
  );

  // pending bits: a new request wins over a same-cycle acknowledge
  always_comb begin
    pend_d = pend_q;
    piv_d = piv_q;
    if (ack_one_in && hit1) begin
      pend_d[idx1] = 1'b0;
      piv_d = PIE_SRC_CODE[idx1];
    end else if (ack_two_in && hit2) begin
      pend_d[idx2] = 1'b0;
      piv_d = PIE_SRC_CODE[idx2];
    end
    pend_d = pend_d | raw_req;
  end

  // reset beats nmi, nmi is software only
  always_comb begin
    st_d = PIE_RUN;
    vec_d = vec_q;
    rst_d = 1'b0;
    nmi_d = 1'b0;
    case (st_q)
      PIE_RUN, PIE_RST, PIE_NMI: begin
        if (wdog_reset_in) begin
          st_d = PIE_RST;
          rst_d = 1'b1;
          vec_d = PIE_VEC_RESET;
        end else if (soft_nmi_in) begin
          st_d = PIE_NMI;
          nmi_d = 1'b1;
          vec_d = PIE_VEC_NMI;
        end else if (hit1) begin
          vec_d = PIE_VEC_LINE_ONE;
        end else if (hit2) begin
          vec_d = PIE_VEC_LINE_TWO;
        end
      end
      default: begin
        st_d = PIE_RUN;
      end
    endcase
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pend_q <= '0;
      piv_q <= PIE_CODE_NONE;
      vec_q <= PIE_VEC_RESET;
      rst_q <= 1'b1;
      nmi_q <= 1'b0;
      st_q <= PIE_RST;
    end else begin
      pend_q <= pend_d;
      piv_q <= piv_d;
      vec_q <= vec_d;
      rst_q <= rst_d;
      nmi_q <= nmi_d;
      st_q <= st_d;
    end
  end

  // visible pending banks
  always_comb begin
    bank0 = '0;
    bank2 = '0;
    for (int i = 0; i < PIE_NSRC; i++) begin
      if (PIE_SRC_BANK[i] == 2'h0) begin
        bank0[PIE_SRC_BIT[i]] = pend_q[i];
      end else begin
        bank2[PIE_SRC_BIT[i]] = pend_q[i];
      end
    end
  end

  assign core_reset_out = rst_q;
  assign nmi_take_out = nmi_q;
  assign core_vector_out = vec_q;
  assign core_line_one_out = hit1;
  assign core_line_two_out = hit2;
  assign peripheral_vector_code_out = piv_q;
  assign pending_request_regs0_out = bank0;
  assign pending_request_regs2_out = bank2;

  // taken acknowledge on each line
  sequence s_ack1;
    ack_one_in && hit1;
  endsequence

  sequence s_ack2;
    ack_two_in && !(ack_one_in && hit1) && hit2;
  endsequence

  // reset and nmi
  a_reset_vector: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    wdog_reset_in |=> core_reset_out && core_vector_out == 16'h0000)
    else $error("reset not taken");
  a_reset_first: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    wdog_reset_in && soft_nmi_in |=> !nmi_take_out)
    else $error("nmi taken over reset");
  a_nmi_vector: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    soft_nmi_in && !wdog_reset_in |=> nmi_take_out && core_vector_out == 16'h0024)
    else $error("nmi vector wrong");

  // gating and priority
  a_mask_gate: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    !core_mask_reg_in[0] |-> !core_line_one_out)
    else $error("line one not masked");
  a_mask_two: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    !core_mask_reg_in[1] |-> !core_line_two_out)
    else $error("line two not masked");
  a_first_one: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    live[0] |-> idx1 == 5'd0)
    else $error("line one priority wrong");
  a_first_two: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    live[10] |-> idx2 == 5'd10)
    else $error("line two priority wrong");
  a_ack_clears: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    s_ack1 ##0 !raw_req[idx1] |=> !pend_q[$past(idx1)])
    else $error("acknowledge did not clear");
  a_ack_two_clears: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    s_ack2 ##0 !raw_req[idx2] |=> !pend_q[$past(idx2)])
    else $error("line two acknowledge did not clear");

  // line one codes
  a_prot_a_code: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    s_ack1 ##0 (idx1 == 5'd0) |=> peripheral_vector_code_out == 16'h0020)
    else $error("protection a code wrong");
  a_prot_b_code: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    s_ack1 ##0 (idx1 == 5'd1) |=> peripheral_vector_code_out == 16'h0019)
    else $error("protection b code wrong");
  a_conv_code: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    s_ack1 ##0 (idx1 == 5'd2) |=> peripheral_vector_code_out == 16'h0004)
    else $error("converter code wrong");
  a_pin_one_code: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    s_ack1 ##0 (idx1 == 5'd3) |=> peripheral_vector_code_out == 16'h0001)
    else $error("pin one code wrong");
  a_pin_two_code: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    s_ack1 ##0 (idx1 == 5'd4) |=> peripheral_vector_code_out == 16'h0011)
    else $error("pin two code wrong");
  a_spi_code: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    s_ack1 ##0 (idx1 == 5'd5) |=> peripheral_vector_code_out == 16'h0005)
    else $error("serial code wrong");
  a_rx_code: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    s_ack1 ##0 (idx1 == 5'd6) |=> peripheral_vector_code_out == 16'h0006)
    else $error("receiver code wrong");
  a_tx_code: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    s_ack1 ##0 (idx1 == 5'd7) |=> peripheral_vector_code_out == 16'h0007)
    else $error("transmitter code wrong");
  a_mailbox_code: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    s_ack1 ##0 (idx1 == 5'd8) |=> peripheral_vector_code_out == 16'h0040)
    else $error("mailbox code wrong");
  a_can_err_code: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    s_ack1 ##0 (idx1 == 5'd9) |=> peripheral_vector_code_out == 16'h0041)
    else $error("can error code wrong");

  // line two codes
  a_cmp1_code: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    s_ack2 ##0 (idx2 == 5'd10) |=> peripheral_vector_code_out == 16'h0021)
    else $error("compare one code wrong");
  a_t1_per_code: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    s_ack2 ##0 (idx2 == 5'd13) |=> peripheral_vector_code_out == 16'h0027)
    else $error("timer one period code wrong");
  a_t1_cmp_code: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    s_ack2 ##0 (idx2 == 5'd14) |=> peripheral_vector_code_out == 16'h0028)
    else $error("timer one compare code wrong");
  a_t1_uf_code: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    s_ack2 ##0 (idx2 == 5'd15) |=> peripheral_vector_code_out == 16'h0029)
    else $error("timer one underflow code wrong");
  a_t1_of_code: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    s_ack2 ##0 (idx2 == 5'd16) |=> peripheral_vector_code_out == 16'h002A)
    else $error("timer one overflow code wrong");
  a_cmp4_code: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    s_ack2 ##0 (idx2 == 5'd17) |=> peripheral_vector_code_out == 16'h0024)
    else $error("compare four code wrong");
  a_t3_per_code: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    s_ack2 ##0 (idx2 == 5'd20) |=> peripheral_vector_code_out == 16'h002F)
    else $error("timer three period code wrong");
  a_t3_cmp_code: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    s_ack2 ##0 (idx2 == 5'd21) |=> peripheral_vector_code_out == 16'h0030)
    else $error("timer three compare code wrong");
  a_t3_uf_code: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    s_ack2 ##0 (idx2 == 5'd22) |=> peripheral_vector_code_out == 16'h0031)
    else $error("timer three underflow code wrong");
  a_t3of_code: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    s_ack2 ##0 (idx2 == 5'd23) |=> peripheral_vector_code_out == 16'h0032)
    else $error("timer three overflow code wrong");

  // pending bit positions, set wins over acknowledge
  a_set_wins: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    raw_req[13] |=> pending_request_regs0_out[12])
    else $error("period event lost");
  a_pin_one_pend: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    raw_req[3] |=> pending_request_regs0_out[2])
    else $error("pin one pending bit wrong");
  a_pin_two_pend: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    raw_req[4] |=> pending_request_regs0_out[3])
    else $error("pin two pending bit wrong");
  a_spi_pend: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    raw_req[5] |=> pending_request_regs0_out[4])
    else $error("serial pending bit wrong");
  a_t1_of_pend: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    raw_req[16] |=> pending_request_regs0_out[15])
    else $error("timer one overflow pending bit wrong");
  a_prot_b_pend: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    raw_req[1] |=> pending_request_regs2_out[0])
    else $error("protection b pending bit wrong");
  a_cmp4_pend: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    raw_req[17] |=> pending_request_regs2_out[1])
    else $error("compare four pending bit wrong");
  a_t3_per_pend: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    raw_req[20] |=> pending_request_regs2_out[4])
    else $error("timer three period pending bit wrong");
  a_t3_of_pend: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    raw_req[23] |=> pending_request_regs2_out[7])
    else $error("timer three overflow pending bit wrong");
endmodule // pie_expander

// >>> rtl/pie_pick.sv
// lowest-index pending request picker for one core line
`timescale 1ns/1ps
module pie_pick
  import pie_pkg::*;
#(
  parameter int LO = 0,
  parameter int HI = 0
) (
  input wire logic [PIE_NSRC-1:0] req_in,
  output logic hit_out,
  output logic [PIE_IDX_W-1:0] idx_out
);
  always_comb begin
    hit_out = 1'b0;
    idx_out = '0;
    for (int i = HI; i >= LO; i--) begin
      if (req_in[i]) begin
        hit_out = 1'b1;
        idx_out = PIE_IDX_W'(i);
      end
    end
  end
endmodule // pie_pick

// >>> rtl/pie_pkg.sv
// constants for the peripheral interrupt expander
package pie_pkg;
  localparam int PIE_NSRC = 24;
  localparam int PIE_IDX_W = 5;
  localparam logic [15:0] PIE_VEC_RESET = 16'h0000;
  localparam logic [15:0] PIE_VEC_NMI = 16'h0024;
  localparam logic [15:0] PIE_VEC_LINE_ONE = 16'h0002;
  localparam logic [15:0] PIE_VEC_LINE_TWO = 16'h0004;
  localparam logic [15:0] PIE_CODE_NONE = 16'h0000;
  // source index order equals overall priority order (priority 4 first)
  localparam int PIE_LINE_ONE_LO = 0;
  localparam int PIE_LINE_ONE_HI = 9;
  localparam int PIE_LINE_TWO_LO = 10;
  localparam int PIE_LINE_TWO_HI = 23;
  localparam logic [15:0] PIE_SRC_CODE [PIE_NSRC] = '{
    16'h0020, 16'h0019, 16'h0004, 16'h0001, 16'h0011, 16'h0005, 16'h0006, 16'h0007,
    16'h0040, 16'h0041, 16'h0021, 16'h0022, 16'h0023, 16'h0027, 16'h0028, 16'h0029,
    16'h002A, 16'h0024, 16'h0025, 16'h0026, 16'h002F, 16'h0030, 16'h0031, 16'h0032};
  // pending register bank (0 or 2) and bit per source
  localparam logic [1:0] PIE_SRC_BANK [PIE_NSRC] = '{
    2'h0, 2'h2, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0,
    2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0,
    2'h0, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2};
  localparam logic [3:0] PIE_SRC_BIT [PIE_NSRC] = '{
    4'h0, 4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6,
    4'h7, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'hE,
    4'hF, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7};
endpackage

// >>> rtl/pie_sync.sv
// two-flop synchroniser for external pins
`timescale 1ns/1ps
module pie_sync
  import pie_pkg::*;
#(
  parameter int W = 1
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= d_in;
      s2_q <= s1_q;
    end
  end
  assign q_out = s2_q;
endmodule // pie_sync

// >>> tb/pie_core_model.sv
// core-side model: acknowledges raised lines, promptly or late
`timescale 1ns/1ps
module pie_core_model (
  input wire logic mclk_in,
  input wire logic line_one_in,
  input wire logic line_two_in,
  input wire logic [1:0] stall_in,
  output logic ack_one_out,
  output logic ack_two_out
);
  logic [1:0] cnt_q = 2'h0;
  logic ack1_q = 1'b0;
  logic ack2_q = 1'b0;
  assign ack_one_out = ack1_q;
  assign ack_two_out = ack2_q;
  always @(posedge mclk_in) begin
    ack1_q <= 1'b0;
    ack2_q <= 1'b0;
    if (cnt_q != 2'h0) begin
      cnt_q <= cnt_q - 2'h1;
    end else if (!ack1_q && !ack2_q && (line_one_in || line_two_in)) begin
      ack1_q <= line_one_in;
      ack2_q <= !line_one_in;
      cnt_q <= stall_in;
    end
  end
endmodule // pie_core_model

// >>> tb/test_peripheral_interrupt_expander.sv
// self-checking bench for the peripheral interrupt expander
`timescale 1ns/1ps
module test_peripheral_interrupt_expander import pie_pkg::*;;
  logic mclk_in = 1'b0, rst_n_in = 1'b0, wdog = 1'b0, nmi = 1'b0;
  logic pa = 1'b0, pb = 1'b0, x1 = 1'b0, x2 = 1'b0, ack1, ack2, took = 1'b0;
  logic [PIE_NSRC-1:0] req = '0, en = '1;
  logic [1:0] mask = 2'h0, stall = 2'h0;
  logic rst_o, nmi_o, l1, l2;
  logic [15:0] vec, code, p0, p2;
  logic [15:0] exp_q[$];
  int n_mismatch = 0, comparisons = 0, cyc = 0, g, k;
  localparam logic [15:0] CODES [24] = '{16'h0020, 16'h0019, 16'h0004, 16'h0001,
    16'h0011, 16'h0005, 16'h0006, 16'h0007, 16'h0040, 16'h0041, 16'h0021, 16'h0022,
    16'h0023, 16'h0027, 16'h0028, 16'h0029, 16'h002A, 16'h0024, 16'h0025, 16'h0026,
    16'h002F, 16'h0030, 16'h0031, 16'h0032};
  localparam int POS [24] = '{0, 16, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14, 15,
    17, 18, 19, 20, 21, 22, 23};

  initial forever #20 mclk_in = ~mclk_in;

  pie_expander pie_expander_i (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .wdog_reset_in(wdog),
    .soft_nmi_in(nmi),
    .periph_req_in(req),
    .power_protect_a_in(pa),
    .power_protect_b_in(pb),
    .ext_irq_pin_one_in(x1),
    .ext_irq_pin_two_in(x2),
    .source_enable_in(en),
    .core_mask_reg_in(mask),
    .ack_one_in(ack1),
    .ack_two_in(ack2),
    .core_reset_out(rst_o),
    .nmi_take_out(nmi_o),
    .core_vector_out(vec),
    .core_line_one_out(l1),
    .core_line_two_out(l2),
    .peripheral_vector_code_out(code),
    .pending_request_regs0_out(p0),
    .pending_request_regs2_out(p2)
  );

  pie_core_model pie_core_model_i (
    .mclk_in(mclk_in),
    .line_one_in(l1),
    .line_two_in(l2),
    .stall_in(stall),
    .ack_one_out(ack1),
    .ack_two_out(ack2)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    if (exp_q.size() != 0) n_mismatch++;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic set_src(input int i);
    case (i)
      0: pa <= 1'b1;
      1: pb <= 1'b1;
      3: x1 <= 1'b1;
      4: x2 <= 1'b1;
      default: req[i] <= 1'b1;
    endcase
  endtask

  task automatic clr();
    @(posedge mclk_in);
    {pa, pb, x1, x2, req} <= '0;
  endtask

  task automatic drain();
    for (int n = 0; n < 60 && exp_q.size() != 0; n++) @(posedge mclk_in);
    repeat (2) @(posedge mclk_in);
  endtask

  // acknowledged code appears one edge after the taken acknowledge
  always @(posedge mclk_in) took <= (ack1 && l1) || (ack2 && l2);
  always @(negedge mclk_in) if (took) check(code, exp_q.pop_front());

  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  initial begin
    void'($urandom(32'h4ce9));
    repeat (15) @(posedge mclk_in);
    @(negedge mclk_in);
    check({rst_o, vec}, 17'h1_0000);
    @(posedge mclk_in);
    rst_n_in <= 1'b1;
    @(posedge mclk_in);
    @(negedge mclk_in);
    check({rst_o, vec}, 17'h0_0000);
    @(posedge mclk_in);
    for (int i = 0; i < PIE_NSRC; i++) begin
      g = $urandom_range(1, 0);
      stall <= 2'($urandom_range(3, 0));
      en <= g ? ~(24'h1 << i) : '1;
      mask <= g ? 2'h3 : 2'h0;
      set_src(i);
      clr();
      repeat (4) @(posedge mclk_in);
      @(negedge mclk_in);
      check({p2, p0}, 32'h1 << POS[i]);
      check({l2, l1}, 2'h0);
      exp_q.push_back(CODES[i]);
      @(posedge mclk_in);
      en <= '1;
      mask <= 2'h3;
      @(negedge mclk_in);
      check({l2, l1}, (i < 10) ? 2'h1 : 2'h2);
      @(negedge mclk_in);
      check(vec, (i < 10) ? 16'h0002 : 16'h0004);
      drain();
      @(negedge mclk_in);
      check({p2, p0}, 32'h0);
      @(posedge mclk_in);
    end
    for (int n = 0; n < 8; n++) begin
      g = $urandom_range(23, 5);
      k = $urandom_range(23, 5);
      if (g != k) begin
        exp_q.push_back(CODES[g < k ? g : k]);
        exp_q.push_back(CODES[g < k ? k : g]);
        set_src(g);
        set_src(k);
        clr();
        drain();
      end
    end
    wdog <= 1'b1;
    mask <= 2'h0;
    @(posedge mclk_in);
    wdog <= 1'b0;
    @(negedge mclk_in);
    check({rst_o, vec}, 17'h1_0000);
    @(posedge mclk_in);
    nmi <= 1'b1;
    @(posedge mclk_in);
    nmi <= 1'b0;
    @(negedge mclk_in);
    check({rst_o, nmi_o, vec}, 18'h1_0024);
    print_verdict();
  end
endmodule // test_peripheral_interrupt_expander
